// >>> core/pucr_cfg.svh
// offsets, field positions, reset values and timing of the user config bank
`ifndef PUCR_CFG_SVH
`define PUCR_CFG_SVH

`define PUCR_OFS_USER_CFG   8'hd1
`define PUCR_OFS_SENSE_IMP  8'hd2
`define PUCR_OFS_RAIL_CFG   8'hd3
`define PUCR_OFS_OK_DELAY   8'hd4
`define PUCR_OFS_INDUCTOR   8'hd6

`define PUCR_RST_USER_CFG   16'h0402
`define PUCR_RST_SENSE_IMP  16'hc200
`define PUCR_RST_OK_DELAY   16'hba00
`define PUCR_RST_INDUCTOR   16'hb23d
`define PUCR_RD_UNMAPPED    16'hffff

`define PUCR_UC_MINDUTY_HI  15
`define PUCR_UC_MINDUTY_LO  11
`define PUCR_UC_STAGE_MODE  10
`define PUCR_UC_MINDUTY_EN  7
`define PUCR_UC_VSET_SEL    5
`define PUCR_UC_MARGIN_EN   4
`define PUCR_UC_LOW_IDLE    3
`define PUCR_UC_OK_PUSHPULL 2
`define PUCR_UC_XT_EN       1
`define PUCR_UC_XT_FAULT    0

`define PUCR_RC_PHASE_HI    15
`define PUCR_RC_PHASE_LO    13
`define PUCR_RC_RAIL_HI     12
`define PUCR_RC_RAIL_LO     8
`define PUCR_RC_COUNT_HI    2
`define PUCR_RC_COUNT_LO    0

`define PUCR_LIN_EXP_HI     15
`define PUCR_LIN_EXP_LO     11
`define PUCR_LIN_MANT_HI    10
`define PUCR_LIN_MANT_LO    0

`define PUCR_CLK_NS         25
`define PUCR_STEP_NS        125
`define PUCR_MS_NS          1000000

`endif

// >>> core/pucr_pkg.sv
// types shared by the user config bank and its output-ok timer
package pucr_pkg;
  typedef logic [15:0] pucr_word_t;
  typedef logic [31:0] pucr_steps_t;
  typedef enum logic [1:0] {
    PUCR_OK_WAIT  = 2'b00,
    PUCR_OK_COUNT = 2'b01,
    PUCR_OK_GOOD  = 2'b10
  } pucr_ok_state_e;
endpackage : pucr_pkg

// >>> core/pucr_ok_timer.sv
// output-ok delay timer: linear word to 125 ns steps, then count
`timescale 1ns/10ps
`include "pucr_cfg.svh"
module pucr_ok_timer #(
  parameter int STEP_CYC = 5
) (
  input  wire logic              sys_clk,
  input  wire logic              rstn,
  input  wire logic              ce,
  input  wire logic              above,
  input  wire pucr_pkg::pucr_word_t delay_word,
  output logic                   ok
);
  import pucr_pkg::*;

  localparam int STEPS_PER_MS = `PUCR_MS_NS / `PUCR_STEP_NS;

  initial begin
    if (STEP_CYC < 1 || STEP_CYC > 255)
      $error("pucr_ok_timer: STEP_CYC out of range");
  end

  // value = mantissa * 2^exponent in ms; negative delays mean none
  function automatic pucr_steps_t lin_to_steps(input pucr_word_t w);
    logic signed [4:0]  e;
    logic signed [10:0] m;
    logic [47:0]        p;
    e = w[`PUCR_LIN_EXP_HI:`PUCR_LIN_EXP_LO];
    m = w[`PUCR_LIN_MANT_HI:`PUCR_LIN_MANT_LO];
    p = 48'h0;
    if (m > 11'sh000) begin
      p = 48'(unsigned'(m)) * 48'(STEPS_PER_MS);
      if (e >= 5'sh00) p = p << unsigned'(e);
      else p = p >> unsigned'(-e);
    end
    // saturate: 32 bits of steps already span beyond 500 s
    lin_to_steps = (p[47:32] != 16'h0) ? 32'hffffffff : p[31:0];
  endfunction : lin_to_steps

  pucr_ok_state_e state;
  pucr_ok_state_e next_state;
  pucr_steps_t    steps;
  pucr_steps_t    next_steps;
  pucr_steps_t    target;
  pucr_steps_t    next_target;
  logic [7:0]     pre;
  logic [7:0]     next_pre;
  logic           next_ok;

  always_comb begin
    next_state  = state;
    next_steps  = steps;
    next_target = target;
    next_pre    = pre;
    next_ok     = 1'b0;
    unique case (state)
      PUCR_OK_WAIT: begin
        next_steps  = 32'h0;
        next_pre    = 8'h0;
        next_target = lin_to_steps(delay_word);
        if (above) begin
          if (next_target == 32'h0) begin
            next_state = PUCR_OK_GOOD;
            next_ok    = 1'b1;
          end else begin
            next_state = PUCR_OK_COUNT;
          end
        end
      end
      PUCR_OK_COUNT: begin
        if (!above) begin
          next_state = PUCR_OK_WAIT;
        end else if (pre == 8'(STEP_CYC - 1)) begin
          next_pre   = 8'h0;
          next_steps = steps + 32'h1;
          if (next_steps >= target) begin
            next_state = PUCR_OK_GOOD;
            next_ok    = 1'b1;
          end
        end else begin
          next_pre = pre + 8'h1;
        end
      end
      PUCR_OK_GOOD: begin
        if (!above) next_state = PUCR_OK_WAIT;
        else next_ok = 1'b1;
      end
      default: next_state = PUCR_OK_WAIT;
    endcase
  end

  always_ff @(posedge sys_clk) begin
    if (!rstn) begin
      state  <= PUCR_OK_WAIT;
      steps  <= 32'h0;
      target <= 32'h0;
      pre    <= 8'h0;
      ok     <= 1'b0;
    end else if (ce) begin
      state  <= next_state;
      steps  <= next_steps;
      target <= next_target;
      pre    <= next_pre;
      ok     <= next_ok;
    end
  end
endmodule : pucr_ok_timer

// >>> core/pucr_regs.sv
// user config command registers and the behaviour they steer
`timescale 1ns/10ps
`include "pucr_cfg.svh"
module pucr_regs #(
  parameter int NCH    = 2,
  parameter int VSET_W = 8,
  parameter int STEP_CYC =
    (`PUCR_STEP_NS + `PUCR_CLK_NS - 1) / `PUCR_CLK_NS
) (
  input  wire logic                         sys_clk,
  input  wire logic                         rstn,
  input  wire logic                         ce,
  input  wire logic [4:0]                   bus_addr_strap,
  input  wire logic                         write_protect,
  input  wire logic                         cmd_valid,
  input  wire logic                         cmd_write,
  input  wire logic [7:0]                   cmd_code,
  input  wire logic                         cmd_page,
  input  wire pucr_pkg::pucr_word_t         cmd_wdata,
  output pucr_pkg::pucr_word_t              rd_data,
  output logic                              rd_valid,
  output logic                              cmd_error,
  input  wire logic [NCH-1:0]               output_enable,
  input  wire logic [NCH-1:0]               pwm_hi_req,
  input  wire logic [NCH-1:0]               pwm_lo_req,
  output logic [NCH-1:0]                    low_side_drive,
  output logic [NCH-1:0]                    high_side_drive,
  output logic [NCH-1:0][6:0]               min_duty_num,
  input  wire logic [NCH-1:0][VSET_W-1:0]   voltage_set_pin_a,
  input  wire logic [NCH-1:0][VSET_W-1:0]   voltage_set_pin_b,
  output logic [NCH-1:0][VSET_W-1:0]        vset_code,
  input  wire logic [NCH-1:0][15:0]         margin_percentage,
  output logic [NCH-1:0]                    margin_from_pct,
  output logic [NCH-1:0][15:0]              margin_pct_used,
  input  wire logic [NCH-1:0]               above_threshold,
  output logic [NCH-1:0]                    output_ok_pin_o,
  output logic [NCH-1:0]                    output_ok_pin_oe,
  output logic [NCH-1:0]                    external_temp_sensor_en,
  input  wire logic [NCH-1:0]               int_temp_fault,
  input  wire logic [NCH-1:0]               ext_temp_fault,
  output logic [NCH-1:0]                    temp_fault,
  input  wire logic [NCH-1:0][7:0]          phase_offset_setting,
  output logic [NCH-1:0][7:0]               phase_offset,
  output logic                              rail_shared,
  output pucr_pkg::pucr_word_t              input_sense_impedance,
  output logic [NCH-1:0][15:0]              inductor_value
);
  import pucr_pkg::*;

  initial begin
    if (NCH != 2) $error("pucr_regs: bank serves exactly two pages");
    if (VSET_W < 1 || VSET_W > 16) $error("pucr_regs: VSET_W unsupported");
  end

  // offset in 1/256 of a period for position pos of cnt+1 phases
  function automatic logic [7:0] spread(input logic [2:0] pos,
                                        input logic [2:0] cnt);
    logic [10:0] num;
    num = {pos, 8'h00};
    spread = 8'(num / (11'(cnt) + 11'h1));
  endfunction : spread

  function automatic logic known_code(input logic [7:0] c);
    known_code = (c == `PUCR_OFS_USER_CFG) || (c == `PUCR_OFS_SENSE_IMP) ||
                 (c == `PUCR_OFS_RAIL_CFG) || (c == `PUCR_OFS_OK_DELAY) ||
                 (c == `PUCR_OFS_INDUCTOR);
  endfunction : known_code

  // register state
  pucr_word_t             user_feature_config [NCH];
  pucr_word_t             rail_phase_config   [NCH];
  pucr_word_t             output_ok_delay     [NCH];
  pucr_word_t             inductor_reg        [NCH];
  pucr_word_t             sense_reg;
  pucr_word_t             next_user_feature_config [NCH];
  pucr_word_t             next_rail_phase_config   [NCH];
  pucr_word_t             next_output_ok_delay     [NCH];
  pucr_word_t             next_inductor_reg        [NCH];
  pucr_word_t             next_sense_reg;
  pucr_word_t             next_rd_data;
  logic                   next_rd_valid;
  logic                   next_cmd_error;

  always_comb begin
    int pg;
    pg = int'(cmd_page);
    next_user_feature_config = user_feature_config;
    next_rail_phase_config   = rail_phase_config;
    next_output_ok_delay     = output_ok_delay;
    next_inductor_reg        = inductor_reg;
    next_sense_reg           = sense_reg;
    next_rd_data             = rd_data;
    next_rd_valid            = 1'b0;
    next_cmd_error           = 1'b0;
    if (cmd_valid) begin
      if (!known_code(cmd_code)) begin
        next_cmd_error = 1'b1;
      end else if (cmd_write) begin
        // protected writes leave every word untouched
        if (write_protect) begin
          next_cmd_error = 1'b1;
        end else begin
          unique case (cmd_code)
            `PUCR_OFS_USER_CFG:  next_user_feature_config[pg] = cmd_wdata;
            `PUCR_OFS_SENSE_IMP: next_sense_reg = cmd_wdata;
            `PUCR_OFS_RAIL_CFG: begin
              // unused bits 7:3 stay zero
              next_rail_phase_config[pg] = {cmd_wdata[15:8], 5'h00,
                                            cmd_wdata[2:0]};
            end
            `PUCR_OFS_OK_DELAY:  next_output_ok_delay[pg] = cmd_wdata;
            `PUCR_OFS_INDUCTOR:  next_inductor_reg[pg] = cmd_wdata;
            default:             next_cmd_error = 1'b1;
          endcase
        end
      end else begin
        next_rd_valid = 1'b1;
        unique case (cmd_code)
          `PUCR_OFS_USER_CFG:  next_rd_data = user_feature_config[pg];
          `PUCR_OFS_SENSE_IMP: next_rd_data = sense_reg;
          `PUCR_OFS_RAIL_CFG:  next_rd_data = rail_phase_config[pg];
          `PUCR_OFS_OK_DELAY:  next_rd_data = output_ok_delay[pg];
          `PUCR_OFS_INDUCTOR:  next_rd_data = inductor_reg[pg];
          default:             next_rd_data = `PUCR_RD_UNMAPPED;
        endcase
      end
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!rstn) begin
      for (int c = 0; c < NCH; c++) begin
        user_feature_config[c] <= `PUCR_RST_USER_CFG;
        // strap is sampled while reset is held, never afterwards
        rail_phase_config[c]   <= {3'h0, bus_addr_strap, 8'h00};
        output_ok_delay[c]     <= `PUCR_RST_OK_DELAY;
        inductor_reg[c]        <= `PUCR_RST_INDUCTOR;
      end
      sense_reg <= `PUCR_RST_SENSE_IMP;
      rd_data   <= 16'h0000;
      rd_valid  <= 1'b0;
      cmd_error <= 1'b0;
    end else if (ce) begin
      user_feature_config <= next_user_feature_config;
      rail_phase_config   <= next_rail_phase_config;
      output_ok_delay     <= next_output_ok_delay;
      inductor_reg        <= next_inductor_reg;
      sense_reg           <= next_sense_reg;
      rd_data             <= next_rd_data;
      rd_valid            <= next_rd_valid;
      cmd_error           <= next_cmd_error;
    end
  end

  // threshold comparator arrives asynchronously: three-stage filter
  logic [NCH-1:0] sync1;
  logic [NCH-1:0] sync2;
  logic [NCH-1:0] sync3;
  logic [NCH-1:0] above_lvl;
  logic [NCH-1:0] next_above_lvl;
  logic [NCH-1:0] ok_lvl;

  always_comb begin
    next_above_lvl = above_lvl;
    for (int c = 0; c < NCH; c++) begin
      if (sync2[c] == sync3[c]) next_above_lvl[c] = sync3[c];
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!rstn) begin
      sync1     <= '0;
      sync2     <= '0;
      sync3     <= '0;
      above_lvl <= '0;
    end else if (ce) begin
      sync1     <= above_threshold;
      sync2     <= sync1;
      sync3     <= sync2;
      above_lvl <= next_above_lvl;
    end
  end

  for (genvar g = 0; g < NCH; g++) begin : g_ok
    pucr_ok_timer #(
      .STEP_CYC (STEP_CYC)
    ) u_timer (
      .sys_clk    (sys_clk),
      .rstn       (rstn),
      .ce         (ce),
      .above      (above_lvl[g]),
      .delay_word (output_ok_delay[g]),
      .ok         (ok_lvl[g])
    );
  end

  // shared rail: both pages name one rail of two phases, distinct slots
  logic share_now;
  assign share_now =
    (rail_phase_config[0][`PUCR_RC_RAIL_HI:`PUCR_RC_RAIL_LO] ==
     rail_phase_config[1][`PUCR_RC_RAIL_HI:`PUCR_RC_RAIL_LO]) &&
    (rail_phase_config[0][`PUCR_RC_COUNT_HI:`PUCR_RC_COUNT_LO] == 3'h1) &&
    (rail_phase_config[1][`PUCR_RC_COUNT_HI:`PUCR_RC_COUNT_LO] == 3'h1) &&
    (rail_phase_config[0][`PUCR_RC_PHASE_HI:`PUCR_RC_PHASE_LO] !=
     rail_phase_config[1][`PUCR_RC_PHASE_HI:`PUCR_RC_PHASE_LO]);

  // derived outputs, all registered
  logic [NCH-1:0]             next_low;
  logic [NCH-1:0]             next_high;
  logic [NCH-1:0][6:0]        next_min_duty;
  logic [NCH-1:0][VSET_W-1:0] next_vset;
  logic [NCH-1:0]             next_margin_en;
  logic [NCH-1:0][15:0]       next_margin;
  logic [NCH-1:0]             next_ok_o;
  logic [NCH-1:0]             next_ok_oe;
  logic [NCH-1:0]             next_xt_en;
  logic [NCH-1:0]             next_tfault;
  logic [NCH-1:0][7:0]        next_offset;

  always_comb begin
    pucr_word_t uc;
    pucr_word_t rc;
    uc = 16'h0000;
    rc = 16'h0000;
    for (int c = 0; c < NCH; c++) begin
      uc = user_feature_config[c];
      rc = rail_phase_config[c];
      if (!output_enable[c]) begin
        next_low[c]  = uc[`PUCR_UC_LOW_IDLE];
        next_high[c] = 1'b0;
      end else if (uc[`PUCR_UC_STAGE_MODE]) begin
        next_low[c]  = 1'b1;
        next_high[c] = pwm_hi_req[c];
      end else begin
        next_low[c]  = pwm_lo_req[c];
        next_high[c] = pwm_hi_req[c];
      end
      // numerator over 512; zero means no floor on the duty cycle
      next_min_duty[c] = 7'h00;
      if (uc[`PUCR_UC_MINDUTY_EN]) begin
        // six-bit sum so that field 31 reaches 64 instead of wrapping
        next_min_duty[c] = {6'(uc[`PUCR_UC_MINDUTY_HI:`PUCR_UC_MINDUTY_LO])
                            + 6'h01, 1'b0};
      end
      next_vset[c] = uc[`PUCR_UC_VSET_SEL] ? voltage_set_pin_b[c] :
                                            voltage_set_pin_a[c];
      next_margin_en[c] = uc[`PUCR_UC_MARGIN_EN];
      next_margin[c]    = uc[`PUCR_UC_MARGIN_EN] ? margin_percentage[c] :
                                                 16'h0000;
      if (uc[`PUCR_UC_OK_PUSHPULL]) begin
        next_ok_o[c]  = ok_lvl[c];
        next_ok_oe[c] = 1'b1;
      end else begin
        next_ok_o[c]  = 1'b0;
        next_ok_oe[c] = ~ok_lvl[c];
      end
      next_xt_en[c]  = uc[`PUCR_UC_XT_EN];
      next_tfault[c] = uc[`PUCR_UC_XT_FAULT] ? ext_temp_fault[c] :
                                              int_temp_fault[c];
      // other devices' phases never count as sharing partners
      next_offset[c] = share_now ?
        spread(rc[`PUCR_RC_PHASE_HI:`PUCR_RC_PHASE_LO],
               rc[`PUCR_RC_COUNT_HI:`PUCR_RC_COUNT_LO]) :
        phase_offset_setting[c];
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!rstn) begin
      // reset word has bit 3 clear and bit 2 clear: no low drive, open-drain
      low_side_drive          <= '0;
      high_side_drive         <= '0;
      min_duty_num            <= '0;
      vset_code               <= '0;
      margin_from_pct         <= '0;
      margin_pct_used         <= '0;
      output_ok_pin_o         <= '0;
      output_ok_pin_oe        <= '1;
      external_temp_sensor_en <= '1;
      temp_fault              <= '0;
      phase_offset            <= '0;
      rail_shared             <= 1'b0;
    end else if (ce) begin
      low_side_drive          <= next_low;
      high_side_drive         <= next_high;
      min_duty_num            <= next_min_duty;
      vset_code               <= next_vset;
      margin_from_pct         <= next_margin_en;
      margin_pct_used         <= next_margin;
      output_ok_pin_o         <= next_ok_o;
      output_ok_pin_oe        <= next_ok_oe;
      external_temp_sensor_en <= next_xt_en;
      temp_fault              <= next_tfault;
      phase_offset            <= next_offset;
      rail_shared             <= share_now;
    end
  end

  assign input_sense_impedance = sense_reg;
  for (genvar g = 0; g < NCH; g++) begin : g_ind
    assign inductor_value[g] = inductor_reg[g];
  end
endmodule : pucr_regs

// >>> tb/pucr_regs_monitor.sv
// port-level checks on the user config bank
`timescale 1ns/10ps
`include "pucr_cfg.svh"
module pucr_regs_monitor #(
  parameter int NCH    = 2,
  parameter int VSET_W = 8
) (
  input wire logic                  sys_clk,
  input wire logic                  rstn,
  input wire logic                  ce,
  input wire logic                  write_protect,
  input wire logic                  cmd_valid,
  input wire logic                  cmd_write,
  input wire logic [7:0]            cmd_code,
  input wire pucr_pkg::pucr_word_t  rd_data,
  input wire logic                  rd_valid,
  input wire logic                  cmd_error,
  input wire logic [NCH-1:0]        output_enable,
  input wire logic [NCH-1:0]        pwm_hi_req,
  input wire logic [NCH-1:0]        high_side_drive,
  input wire logic [NCH-1:0]        margin_from_pct,
  input wire logic [NCH-1:0][15:0]  margin_pct_used,
  input wire logic [NCH-1:0]        above_threshold,
  input wire logic [NCH-1:0]        output_ok_pin_o,
  input wire logic [NCH-1:0]        output_ok_pin_oe
);
  import pucr_pkg::*;
  logic mapped;
  logic ok_lvl;
  assign mapped = cmd_code inside {`PUCR_OFS_USER_CFG, `PUCR_OFS_SENSE_IMP,
    `PUCR_OFS_RAIL_CFG, `PUCR_OFS_OK_DELAY, `PUCR_OFS_INDUCTOR};
  // open-drain drives low for not-ok, so the pin level folds both modes
  assign ok_lvl = output_ok_pin_o[0] | ~output_ok_pin_oe[0];
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rstn);
  a_read_answer: assert property (
    cmd_valid && ce && !cmd_write && mapped |=> rd_valid && !cmd_error)
    else $error("mapped read got no data pulse");
  a_bad_code: assert property (
    cmd_valid && ce && !mapped |=> cmd_error && !rd_valid)
    else $error("unknown code not refused");
  a_protect_refuse: assert property (
    cmd_valid && ce && cmd_write && write_protect |=> cmd_error)
    else $error("protected write not refused");
  a_rdata_hold: assert property (
    !$stable(rd_data) |-> rd_valid && $past(cmd_valid && !cmd_write))
    else $error("read data moved without a read");
  a_high_follow: assert property (
    rstn && ce && output_enable[0] |=>
      high_side_drive[0] == $past(pwm_hi_req[0]))
    else $error("high drive does not follow request");
  a_high_idle: assert property (
    ce && !output_enable[0] |=> !high_side_drive[0])
    else $error("high drive active while disabled");
  a_margin_off: assert property (
    !margin_from_pct[0] |-> margin_pct_used[0] == 16'h0000)
    else $error("margin percentage used while off");
  a_ok_pin_style: assert property (
    output_ok_pin_o[0] |-> output_ok_pin_oe[0])
    else $error("ok pin high while not driven");
  a_ok_after_above: assert property (
    $rose(ok_lvl) |-> $past(above_threshold[0], 3))
    else $error("ok rose without threshold");
  a_ok_drop: assert property (
    (ce && !above_threshold[0]) [*7] |-> !ok_lvl)
    else $error("ok held after threshold lost");
  c_read: cover property (rd_valid);
  c_error: cover property (cmd_error);
  c_ok: cover property ($rose(ok_lvl));
endmodule : pucr_regs_monitor

bind pucr_regs pucr_regs_monitor #(.NCH(NCH), .VSET_W(VSET_W)) u_mon (
  .sys_clk, .rstn, .ce, .write_protect, .cmd_valid, .cmd_write, .cmd_code,
  .rd_data, .rd_valid, .cmd_error, .output_enable, .pwm_hi_req,
  .high_side_drive, .margin_from_pct, .margin_pct_used, .above_threshold,
  .output_ok_pin_o, .output_ok_pin_oe);

// >>> tb/pucr_host_model.sv
// host side of the command port: one command, then its answer
`timescale 1ns/10ps
module pucr_host_model (
  input  wire logic                 sys_clk,
  input  wire pucr_pkg::pucr_word_t rd_data,
  input  wire logic                 rd_valid,
  input  wire logic                 cmd_error,
  output logic                      cmd_valid,
  output logic                      cmd_write,
  output logic [7:0]                cmd_code,
  output logic                      cmd_page,
  output pucr_pkg::pucr_word_t      cmd_wdata
);
  import pucr_pkg::*;
  initial begin
    cmd_valid = 1'b0;
    cmd_write = 1'b0;
    cmd_code  = 8'h00;
    cmd_page  = 1'b0;
    cmd_wdata = 16'h0000;
  end
  // call just after a rising edge; returns at the edge holding the answer
  task automatic xfer(input logic w, input logic [7:0] c, input logic p,
                      input pucr_word_t wd, output pucr_word_t d,
                      output logic v, output logic e);
    cmd_valid <= 1'b1;
    cmd_write <= w;
    cmd_code  <= c;
    cmd_page  <= p;
    cmd_wdata <= wd;
    @(posedge sys_clk);
    // idle bus shows junk so a stale code is never mistaken for a command
    cmd_valid <= 1'b0;
    cmd_code  <= ~c;
    cmd_wdata <= ~wd;
    @(posedge sys_clk);
    d = rd_data;
    v = rd_valid;
    e = cmd_error;
  endtask : xfer
endmodule : pucr_host_model

// >>> tb/power_ctrl_user_config_regs_test.sv
// testbench for the user config bank
`timescale 1ns/10ps
`include "pucr_cfg.svh"
module power_ctrl_user_config_regs_test;
  import pucr_pkg::*;
  logic sys_clk = 1'b0;
  logic rstn = 1'b0;
  logic ce = 1'b1;
  logic write_protect = 1'b0;
  logic [4:0] bus_addr_strap = 5'h15;
  logic cmd_valid, cmd_write, cmd_page, rd_valid, cmd_error, rail_shared;
  logic v, er;
  logic [7:0] cmd_code;
  pucr_word_t cmd_wdata, rd_data, input_sense_impedance, d;
  logic [1:0] output_enable = 2'b01, pwm_hi_req = 2'b01, pwm_lo_req = 2'b10;
  logic [1:0] above_threshold = 2'b00, int_temp_fault = 2'b01;
  logic [1:0] ext_temp_fault = 2'b00, temp_fault, margin_from_pct;
  logic [1:0] low_side_drive, high_side_drive, external_temp_sensor_en;
  logic [1:0] output_ok_pin_o, output_ok_pin_oe;
  logic [1:0][6:0] min_duty_num;
  logic [1:0][7:0] voltage_set_pin_a = {8'h21, 8'h11};
  logic [1:0][7:0] voltage_set_pin_b = {8'h42, 8'h22};
  logic [1:0][7:0] phase_offset_setting = {8'h90, 8'h40};
  logic [1:0][7:0] vset_code, phase_offset;
  logic [1:0][15:0] margin_percentage = {16'h1234, 16'hca80};
  logic [1:0][15:0] margin_pct_used, inductor_value;
  int err_count = 0;
  int cmp_count = 0;
  int n;

  // short timer step keeps the 1 ms wait at 8000 cycles
  pucr_regs #(.STEP_CYC(1)) uut (
    .sys_clk, .rstn, .ce, .bus_addr_strap, .write_protect, .cmd_valid,
    .cmd_write, .cmd_code, .cmd_page, .cmd_wdata, .rd_data, .rd_valid,
    .cmd_error, .output_enable, .pwm_hi_req, .pwm_lo_req, .low_side_drive,
    .high_side_drive, .min_duty_num, .voltage_set_pin_a, .voltage_set_pin_b,
    .vset_code, .margin_percentage, .margin_from_pct, .margin_pct_used,
    .above_threshold, .output_ok_pin_o, .output_ok_pin_oe,
    .external_temp_sensor_en, .int_temp_fault, .ext_temp_fault, .temp_fault,
    .phase_offset_setting, .phase_offset, .rail_shared,
    .input_sense_impedance, .inductor_value);

  pucr_host_model host (
    .sys_clk, .rd_data, .rd_valid, .cmd_error, .cmd_valid, .cmd_write,
    .cmd_code, .cmd_page, .cmd_wdata);

  always #12.5 sys_clk = ~sys_clk;

  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      err_count++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check

  task automatic cmd(input logic w, input logic [7:0] c, input logic p,
                     input pucr_word_t wd, input logic [1:0] f);
    host.xfer(w, c, p, wd, d, v, er);
    check({14'h0, v, er}, {14'h0, f});
  endtask : cmd

  task automatic rd(input logic [7:0] c, input logic p, input pucr_word_t e);
    cmd(1'b0, c, p, 16'h0000, 2'b10);
    check(d, e);
  endtask : rd

  // derived outputs settle one cycle after the word lands
  task automatic ucfg(input pucr_word_t w);
    // a host stores the word right after this write; no store here
    cmd(1'b1, `PUCR_OFS_USER_CFG, 1'b0, w, 2'b00);
    repeat (2) @(posedge sys_clk);
  endtask : ucfg

  task automatic stop_test;
    $display("comparisons %0d, mismatches %0d", cmp_count, err_count);
    if (err_count == 0 && cmp_count > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask : stop_test

  initial begin
    #(25 * 30000);
    err_count++;
    stop_test();
  end

  initial begin
    repeat (3) @(posedge sys_clk);
    rstn <= 1'b1;
    @(posedge sys_clk);
    for (int p = 0; p < 2; p++) begin
      rd(`PUCR_OFS_USER_CFG, p[0], 16'h0402);
      rd(`PUCR_OFS_RAIL_CFG, p[0], 16'h1500);
      rd(`PUCR_OFS_OK_DELAY, p[0], 16'hba00);
      rd(`PUCR_OFS_INDUCTOR, p[0], 16'hb23d);
    end
    rd(`PUCR_OFS_SENSE_IMP, 1'b0, 16'hc200);
    check({14'h0, external_temp_sensor_en}, 16'h0003);
    check({14'h0, output_ok_pin_oe}, 16'h0003);
    cmd(1'b0, 8'hd5, 1'b0, 16'h0000, 2'b01);
    write_protect <= 1'b1;
    cmd(1'b1, `PUCR_OFS_USER_CFG, 1'b0, 16'hffff, 2'b01);
    write_protect <= 1'b0;
    rd(`PUCR_OFS_USER_CFG, 1'b0, 16'h0402);
    cmd(1'b1, `PUCR_OFS_SENSE_IMP, 1'b1, 16'h0a01, 2'b00);
    rd(`PUCR_OFS_SENSE_IMP, 1'b0, 16'h0a01);
    check(input_sense_impedance, 16'h0a01);
    cmd(1'b1, `PUCR_OFS_INDUCTOR, 1'b1, 16'h1234, 2'b00);
    rd(`PUCR_OFS_INDUCTOR, 1'b0, 16'hb23d);
    check(inductor_value[1], 16'h1234);
    check({15'h0, rail_shared}, 16'h0000);
    check(phase_offset, phase_offset_setting);
    // same rail id, two phases, positions given in order
    cmd(1'b1, `PUCR_OFS_RAIL_CFG, 1'b0, 16'h1501, 2'b00);
    cmd(1'b1, `PUCR_OFS_RAIL_CFG, 1'b1, 16'h3501, 2'b00);
    repeat (2) @(posedge sys_clk);
    check({15'h0, rail_shared}, 16'h0001);
    check(phase_offset, 16'h8000);
    cmd(1'b1, `PUCR_OFS_RAIL_CFG, 1'b0, 16'hffff, 2'b00);
    rd(`PUCR_OFS_RAIL_CFG, 1'b0, 16'hff07);
    ucfg(16'hf880);
    check({9'h0, min_duty_num[0]}, 16'h0040);
    ucfg(16'h0080);
    check({9'h0, min_duty_num[0]}, 16'h0002);
    ucfg(16'hf800);
    check({9'h0, min_duty_num[0]}, 16'h0000);
    ucfg(16'h0000);
    check({14'h0, low_side_drive[0], high_side_drive[0]}, 16'h1);
    ucfg(16'h0400);
    check({14'h0, low_side_drive[0], high_side_drive[0]}, 16'h3);
    output_enable <= 2'b00;
    ucfg(16'h0008);
    check({14'h0, low_side_drive[0], high_side_drive[0]}, 16'h2);
    ucfg(16'h0000);
    check({14'h0, low_side_drive[0], high_side_drive[0]}, 16'h0);
    output_enable <= 2'b01;
    ucfg(16'h0020);
    check({8'h0, vset_code[0]}, 16'h0022);
    ucfg(16'h0010);
    check({8'h0, vset_code[0]}, 16'h0011);
    check({15'h0, margin_from_pct[0]}, 16'h0001);
    check(margin_pct_used[0], 16'hca80);
    ucfg(16'h0002);
    check(margin_pct_used[0], 16'h0000);
    check({14'h0, external_temp_sensor_en[0], temp_fault[0]}, 16'h3);
    ucfg(16'h0003);
    check({14'h0, external_temp_sensor_en[0], temp_fault[0]}, 16'h2);
    ucfg(16'h0001);
    check({14'h0, external_temp_sensor_en[0], temp_fault[0]}, 16'h0);
    // push-pull, default 1 ms delay kept as a host should
    ucfg(16'h0004);
    above_threshold <= 2'b01;
    for (n = 0; n < 9000 && output_ok_pin_o[0] !== 1'b1; n++) begin
      @(posedge sys_clk);
    end
    check({15'h0, n >= 8000 && n <= 8012}, 16'h0001);
    ucfg(16'h0000);
    check({14'h0, output_ok_pin_o[0], output_ok_pin_oe[0]}, 16'h0);
    above_threshold <= 2'b00;
    repeat (10) @(posedge sys_clk);
    check({14'h0, output_ok_pin_o[0], output_ok_pin_oe[0]}, 16'h1);
    cmd(1'b1, `PUCR_OFS_OK_DELAY, 1'b0, 16'h0000, 2'b00);
    above_threshold <= 2'b01;
    repeat (10) @(posedge sys_clk);
    check({14'h0, output_ok_pin_o[0], output_ok_pin_oe[0]}, 16'h0);
    stop_test();
  end
endmodule : power_ctrl_user_config_regs_test
